/* core/sles_engine.sv */
// step logic scan engine: wishbone registers, step program, scan sequencer, monitors
`timescale 1ns/1ps
module sles_engine #(
   parameter int MS_CYCLES = sles_pkg::MS_CYCLES,
   parameter int AIN_W     = 16
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // wishbone slave
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [7:0]                    adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   // field signals
   input  wire logic [sles_pkg::N_TERMS-1:0]  term_i,
   input  wire logic [AIN_W-1:0]              ain0_i,
   input  wire logic [AIN_W-1:0]              ain1_i,
   output logic      [sles_pkg::N_OUTS-1:0]   logic_out_o
);
   import sles_pkg::*;

   // registers
   logic                     enable_ff;
   logic [4:0]               period_ff;
   logic [7:0]               nsteps_ff;
   logic [7:0]               monsel_ff;
   logic [63:0]              assign_ff;
   logic [7:0]               paddr_ff;
   logic [7:0]               osel_ff [N_OUTS];
   logic [31:0]              prog_mem [N_STEPS];
   logic                     ack_ff;
   logic [31:0]              dat_ff;
   // scan state
   sles_state_t              state_ff;
   logic [7:0]               cur_ff;
   logic [N_TERMS-1:0]       term_lat_ff;
   logic [AIN_W-1:0]         ain_lat_ff [2];
   logic [N_STEPS-1:0]       res_ff;
   logic [N_STEPS-1:0]       prev_a_ff;
   logic [PRE_W-1:0]         tmr_ff [N_STEPS];
   logic [AIN_W-1:0]         aout_ff [N_STEPS];
   logic [N_OUTS-1:0]        out_ff;
   logic [4:0]               per_lat_ff;
   // monitors
   logic [31:0]              mon_dio_ff;
   logic [PRE_W-1:0]         mon_tmr_ff;
   logic [AIN_W-1:0]         mon_ai1_ff;
   logic [AIN_W-1:0]         mon_ai2_ff;
   logic [AIN_W-1:0]         mon_ao_ff;

   sles_cyc_if cyc ();

   sles_cycle_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cyc   (cyc.gen)
   );

   // ---------------- helpers ----------------
   function automatic logic src_bit(input logic [7:0] s, input logic [N_STEPS-1:0] r,
                                    input logic [N_TERMS-1:0] t);
      logic v;
      v = 1'b0;
      if (s >= 8'h01 && s <= LIM_20MS)
         v = r[s - 8'h01];
      else if (s[7:3] == SRC_TERM_HI)
         v = t[s[2:0]];
      return v;
   endfunction

   function automatic logic term_func(input logic [63:0] codes, input logic [N_TERMS-1:0] t,
                                      input logic [7:0] code);
      logic v;
      v = 1'b0;
      for (int k = 0; k < N_TERMS; k++)
         if (codes[8*k +: 8] == code && t[k])
            v = 1'b1;
      return v;
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] v;
      v = old;
      for (int k = 0; k < 4; k++)
         if (be[k])
            v[8*k +: 8] = nw[8*k +: 8];
      return v;
   endfunction

   // ---------------- control inputs and period ----------------
   logic       cancel;
   logic       tclear;
   logic [4:0] per_ms;
   logic       over_lim;
   logic       run_ok;

   assign cancel = term_func(assign_ff, term_i, CODE_CANCEL);
   assign tclear = term_func(assign_ff, term_i, CODE_TCLEAR);

   always_comb begin
      per_ms   = PER_20MS;
      over_lim = (nsteps_ff > LIM_20MS);
      if (period_ff == PER_2MS) begin
         per_ms   = PER_2MS;
         over_lim = (nsteps_ff > LIM_2MS);
      end else if (period_ff == PER_5MS) begin
         per_ms   = PER_5MS;
         over_lim = (nsteps_ff > LIM_5MS);
      end else if (period_ff == PER_10MS) begin
         per_ms   = PER_10MS;
         over_lim = (nsteps_ff > LIM_10MS);
      end else if (period_ff != PER_20MS) begin
         // automatic: shortest of 2, 5 and 10 ms that fits the used steps; 10 ms for any count above 50
         if (nsteps_ff <= LIM_2MS)
            per_ms = PER_2MS;
         else if (nsteps_ff <= LIM_5MS)
            per_ms = PER_5MS;
         else
            per_ms = PER_10MS;
      end
   end

   assign cyc.period_ms = per_ms;
   assign run_ok = enable_ff && !cancel && !over_lim && (nsteps_ff != 8'h00);

   // ---------------- wishbone slave ----------------
   logic req;
   logic wr;
   logic [31:0] rd;
   assign req = cyc_i && stb_i && !ack_ff;
   assign wr  = req && we_i;

   always_comb begin
      rd = '0;
      if (adr_i == REG_CTRL)
         rd = {31'h0, enable_ff};
      else if (adr_i == REG_PERIOD)
         rd = {27'h0, period_ff};
      else if (adr_i == REG_NSTEPS)
         rd = {24'h0, nsteps_ff};
      else if (adr_i == REG_MONSEL)
         rd = {24'h0, monsel_ff};
      else if (adr_i == REG_TASG_LO)
         rd = assign_ff[31:0];
      else if (adr_i == REG_TASG_HI)
         rd = assign_ff[63:32];
      else if (adr_i == REG_STATUS)
         rd = {6'h0, out_ff, 8'h0, 3'h0, state_ff == ST_EVAL, over_lim, tclear, cancel, enable_ff};
      else if (adr_i == REG_PADDR)
         rd = {24'h0, paddr_ff};
      else if (adr_i == REG_PDATA)
         rd = (paddr_ff >= 8'h01 && paddr_ff <= LIM_20MS) ? prog_mem[paddr_ff - 8'h01] : 32'h0;
      else if (adr_i >= REG_OSEL0 && adr_i < REG_OSEL0 + 8'(4 * N_OUTS) && adr_i[1:0] == 2'b00)
         rd = {24'h0, osel_ff[adr_i[5:2]]};
      else if (adr_i == REG_MON_DIO)
         rd = (monsel_ff == 8'h00) ? 32'h0 : mon_dio_ff;
      else if (adr_i == REG_MON_TMR)
         rd = (monsel_ff == 8'h00) ? 32'h0 : 32'(mon_tmr_ff);
      else if (adr_i == REG_MON_AI1)
         rd = (monsel_ff == 8'h00) ? 32'h0 : 32'(mon_ai1_ff);
      else if (adr_i == REG_MON_AI2)
         rd = (monsel_ff == 8'h00) ? 32'h0 : 32'(mon_ai2_ff);
      else if (adr_i == REG_MON_AO)
         rd = (monsel_ff == 8'h00) ? 32'h0 : 32'(mon_ao_ff);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
      end else begin
         ack_ff <= req;
         if (req && !we_i)
            dat_ff <= rd;
      end
   end

   // monitor words take no write: only listed registers decode below
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_ff <= RST_ENABLE;
         period_ff <= RST_PERIOD;
         nsteps_ff <= RST_NSTEPS;
         monsel_ff <= RST_MONSEL;
         assign_ff <= '0;
         paddr_ff  <= '0;
         for (int k = 0; k < N_OUTS; k++)
            osel_ff[k] <= '0;
      end else if (wr) begin
         if (adr_i == REG_CTRL && sel_i[0])
            enable_ff <= dat_i[0];
         else if (adr_i == REG_PERIOD && sel_i[0])
            period_ff <= dat_i[4:0];
         else if (adr_i == REG_NSTEPS && sel_i[0])
            nsteps_ff <= dat_i[7:0];
         else if (adr_i == REG_MONSEL && sel_i[0])
            monsel_ff <= dat_i[7:0];
         else if (adr_i == REG_TASG_LO)
            assign_ff[31:0] <= be_merge(assign_ff[31:0], dat_i, sel_i);
         else if (adr_i == REG_TASG_HI)
            assign_ff[63:32] <= be_merge(assign_ff[63:32], dat_i, sel_i);
         else if (adr_i == REG_PADDR && sel_i[0])
            paddr_ff <= dat_i[7:0];
         else if (adr_i >= REG_OSEL0 && adr_i < REG_OSEL0 + 8'(4 * N_OUTS) && adr_i[1:0] == 2'b00
                  && sel_i[0])
            osel_ff[adr_i[5:2]] <= dat_i[7:0];
      end
   end

   // program store has no reset; it is loaded by software before enabling
   always_ff @(posedge clk_i) begin
      if (wr && adr_i == REG_PDATA && paddr_ff >= 8'h01 && paddr_ff <= LIM_20MS)
         prog_mem[paddr_ff - 8'h01] <= be_merge(prog_mem[paddr_ff - 8'h01], dat_i, sel_i);
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

   // ---------------- step evaluation ----------------
   logic [31:0]      w;
   logic [3:0]       op;
   logic             a;
   logic             b;
   logic [AIN_W-1:0] ana;
   logic [AIN_W-1:0] anb;
   logic [PRE_W-1:0] pre;
   logic [PRE_W-1:0] t_old;
   logic [PRE_W-1:0] t_new;
   logic [AIN_W-1:0] ao_new;
   logic             r;
   logic [PRE_W:0]   t_sum;

   always_comb begin
      w      = prog_mem[cur_ff];
      op     = w[OP_LSB +: OP_W];
      // results of lower steps are already this cycle's, higher ones still last cycle's
      a      = src_bit(w[SA_LSB +: SRC_W], res_ff, term_lat_ff);
      b      = src_bit(w[SB_LSB +: SRC_W], res_ff, term_lat_ff);
      ana    = ain_lat_ff[w[SA_LSB]];
      anb    = ain_lat_ff[w[SB_LSB]];
      pre    = w[PRE_LSB +: PRE_W];
      t_old  = tmr_ff[cur_ff];
      t_new  = t_old;
      ao_new = aout_ff[cur_ff];
      r      = 1'b0;
      t_sum  = '0;
      case (op)
         OP_AND: r = a & b;
         OP_OR:  r = a | b;
         OP_XOR: r = a ^ b;
         OP_NOT: r = ~a;
         OP_TON: begin
            // on-delay: accumulates elapsed ms while the input holds
            t_sum = {1'b0, t_old} + (PRE_W + 1)'(per_lat_ff);
            if (!a)
               t_new = '0;
            else if (t_sum[PRE_W] || t_sum[PRE_W-1:0] >= pre)
               t_new = pre;
            else
               t_new = t_sum[PRE_W-1:0];
            r = a && (t_new >= pre);
         end
         OP_CNT: begin
            // counts rising edges of a, b resets
            if (b)
               t_new = '0;
            else if (a && !prev_a_ff[cur_ff] && t_old != '1)
               t_new = t_old + PRE_W'(1);
            r = (t_new >= pre);
         end
         OP_ADD: begin
            ao_new = ana + anb;
            r      = (ao_new != '0);
         end
         OP_CMP: r = (ana >= anb);
         default: r = 1'b0;
      endcase
   end

   // ---------------- scan sequencer ----------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         cur_ff   <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (cyc.cycle_start && run_ok) begin
                  state_ff <= ST_EVAL;
                  cur_ff   <= '0;
               end
            end
            ST_EVAL: begin
               if (cancel)
                  state_ff <= ST_IDLE;
               else if (cur_ff == nsteps_ff - 8'h01)
                  state_ff <= ST_UPDATE;
               else
                  cur_ff <= cur_ff + 8'h01;
            end
            ST_UPDATE: state_ff <= ST_IDLE;
            default:   state_ff <= ST_IDLE;
         endcase
      end
   end

   // input latch: steps only ever see these copies during a cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_lat_ff   <= '0;
         ain_lat_ff[0] <= '0;
         ain_lat_ff[1] <= '0;
         per_lat_ff    <= PER_2MS;
      end else if (state_ff == ST_IDLE && cyc.cycle_start) begin
         term_lat_ff   <= term_i;
         ain_lat_ff[0] <= ain0_i;
         ain_lat_ff[1] <= ain1_i;
         per_lat_ff    <= per_ms;
      end
   end

   // sequence state: results, edge memories and analog outputs
   always_ff @(posedge clk_i) begin
      if (rst_i || cancel) begin
         res_ff    <= '0;
         prev_a_ff <= '0;
         for (int k = 0; k < N_STEPS; k++)
            aout_ff[k] <= '0;
      end else if (state_ff == ST_EVAL) begin
         res_ff[cur_ff]    <= r;
         prev_a_ff[cur_ff] <= a;
         aout_ff[cur_ff]   <= ao_new;
      end
   end

   // timers and counters: held at zero while clear or cancel is asserted
   always_ff @(posedge clk_i) begin
      if (rst_i || cancel || tclear) begin
         for (int k = 0; k < N_STEPS; k++)
            tmr_ff[k] <= '0;
      end else if (state_ff == ST_EVAL) begin
         tmr_ff[cur_ff] <= t_new;
      end
   end

   // outputs change only here, all together
   always_ff @(posedge clk_i) begin
      if (rst_i || cancel) begin
         out_ff <= '0;
      end else if (state_ff == ST_UPDATE) begin
         for (int k = 0; k < N_OUTS; k++)
            out_ff[k] <= src_bit(osel_ff[k], res_ff, term_lat_ff);
      end
   end

   assign logic_out_o = out_ff;

   // monitors follow the selected step as it is evaluated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_dio_ff <= '0;
         mon_tmr_ff <= '0;
         mon_ai1_ff <= '0;
         mon_ai2_ff <= '0;
         mon_ao_ff  <= '0;
      end else if (state_ff == ST_EVAL && monsel_ff == cur_ff + 8'h01) begin
         mon_dio_ff <= {29'h0, r, b, a};
         mon_tmr_ff <= t_new;
         mon_ai1_ff <= ana;
         mon_ai2_ff <= anb;
         mon_ao_ff  <= ao_new;
      end
   end
endmodule

/* core/sles_pkg.sv */
// constants, register map and program-word layout of the step logic scan engine
package sles_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // sizes
   localparam int N_STEPS = 200;
   localparam int N_OUTS  = 10;
   localparam int N_TERMS = 8;

   // period settings and step limits
   localparam logic [4:0] PER_AUTO = 5'h00;
   localparam logic [4:0] PER_2MS  = 5'h02;
   localparam logic [4:0] PER_5MS  = 5'h05;
   localparam logic [4:0] PER_10MS = 5'h0a;
   localparam logic [4:0] PER_20MS = 5'h14;
   localparam logic [7:0] LIM_2MS  = 8'h0a;
   localparam logic [7:0] LIM_5MS  = 8'h32;
   localparam logic [7:0] LIM_10MS = 8'h64;
   localparam logic [7:0] LIM_20MS = 8'hc8;

   // terminal function codes
   localparam logic [7:0] CODE_CANCEL = 8'h50;
   localparam logic [7:0] CODE_TCLEAR = 8'h51;

   // register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_PERIOD  = 8'h04;
   localparam logic [7:0] REG_NSTEPS  = 8'h08;
   localparam logic [7:0] REG_MONSEL  = 8'h0c;
   localparam logic [7:0] REG_TASG_LO = 8'h10;
   localparam logic [7:0] REG_TASG_HI = 8'h14;
   localparam logic [7:0] REG_STATUS  = 8'h18;
   localparam logic [7:0] REG_PADDR   = 8'h1c;
   localparam logic [7:0] REG_PDATA   = 8'h20;
   localparam logic [7:0] REG_OSEL0   = 8'h40;
   localparam logic [7:0] REG_MON_DIO = 8'h80;
   localparam logic [7:0] REG_MON_TMR = 8'h84;
   localparam logic [7:0] REG_MON_AI1 = 8'h88;
   localparam logic [7:0] REG_MON_AI2 = 8'h8c;
   localparam logic [7:0] REG_MON_AO  = 8'h90;

   // reset values
   localparam logic       RST_ENABLE = 1'b0;
   localparam logic [4:0] RST_PERIOD = 5'h00;
   localparam logic [7:0] RST_NSTEPS = 8'h00;
   localparam logic [7:0] RST_MONSEL = 8'h00;

   // program word fields
   localparam int OP_LSB  = 0;
   localparam int OP_W    = 4;
   localparam int SA_LSB  = 4;
   localparam int SB_LSB  = 12;
   localparam int SRC_W   = 8;
   localparam int PRE_LSB = 20;
   localparam int PRE_W   = 12;

   // source codes: 1..200 step result, 0xf0..0xf7 latched terminal
   localparam logic [4:0] SRC_TERM_HI = 5'h1e;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_AND  = 4'h1,
      OP_OR   = 4'h2,
      OP_XOR  = 4'h3,
      OP_NOT  = 4'h4,
      OP_TON  = 4'h5,
      OP_CNT  = 4'h6,
      OP_ADD  = 4'h7,
      OP_CMP  = 4'h8
   } sles_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_EVAL   = 3'b010,
      ST_UPDATE = 3'b100
   } sles_state_t;
endpackage

/* core/sles_cyc_if.sv */
// scan cycle timing signals between engine and cycle timer
`timescale 1ns/1ps
interface sles_cyc_if;
   logic [4:0] period_ms;
   logic       ms_tick;
   logic       cycle_start;

   modport gen (input period_ms, output ms_tick, output cycle_start);
   modport use_side (output period_ms, input ms_tick, input cycle_start);
endinterface

/* core/sles_cycle_timer.sv */
// millisecond divider and scan cycle start generator
`timescale 1ns/1ps
module sles_cycle_timer #(
   parameter int MS_CYCLES = sles_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // cycle timing
   sles_cyc_if.gen   cyc
);
   import sles_pkg::*;

   logic [16:0] div_ff;
   logic [4:0]  ms_ff;
   logic        tick_ff;
   logic        start_ff;
   logic [4:0]  per;

   // a zero period would wrap to a 32 ms cycle; fall back to the longest
   assign per = (cyc.period_ms == 5'h00) ? PER_20MS : cyc.period_ms;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else if (div_ff >= 17'(MS_CYCLES - 1)) begin
         div_ff  <= '0;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + 17'h00001;
         tick_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_ff    <= '0;
         start_ff <= 1'b0;
      end else if (tick_ff) begin
         if (ms_ff >= per - 5'h01) begin
            ms_ff    <= '0;
            start_ff <= 1'b1;
         end else begin
            ms_ff    <= ms_ff + 5'h01;
            start_ff <= 1'b0;
         end
      end else begin
         start_ff <= 1'b0;
      end
   end

   assign cyc.ms_tick     = tick_ff;
   assign cyc.cycle_start = start_ff;
endmodule

/* tb/sles_engine_sva.sv */
// assertions on the scan engine ports
`timescale 1ns/1ps
module sles_engine_sva
   import sles_pkg::*;
#(
   parameter int MS_CYCLES = sles_pkg::MS_CYCLES,
   parameter int AIN_W     = 16
) (
   // clock and reset
   input wire logic                         clk_i,
   input wire logic                         rst_i,
   // wishbone
   input wire logic                         cyc_i,
   input wire logic                         stb_i,
   input wire logic                         we_i,
   input wire logic [7:0]                   adr_i,
   input wire logic [3:0]                   sel_i,
   input wire logic [31:0]                  dat_i,
   input wire logic [31:0]                  dat_o,
   input wire logic                         ack_o,
   // field
   input wire logic [sles_pkg::N_TERMS-1:0] term_i,
   input wire logic [AIN_W-1:0]             ain0_i,
   input wire logic [AIN_W-1:0]             ain1_i,
   input wire logic [sles_pkg::N_OUTS-1:0]  logic_out_o
);
   logic        take;
   logic        cancel;
   logic        en_ff;
   logic [7:0]  sel_ff;
   logic [63:0] code_ff;

   assign take = cyc_i && stb_i && !ack_o;

   // mirrors move on the same edge as the design registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff  <= RST_ENABLE;
         sel_ff <= RST_MONSEL;
      end else if (take && we_i && sel_i[0]) begin
         if (adr_i == REG_CTRL) begin
            en_ff <= dat_i[0];
         end
         if (adr_i == REG_MONSEL) begin
            sel_ff <= dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 8; i++) begin
         if (rst_i) begin
            code_ff[i*8+:8] <= 8'h00;
         end else if (take && we_i && sel_i[i%4] && adr_i == (i < 4 ? REG_TASG_LO : REG_TASG_HI)) begin
            code_ff[i*8+:8] <= dat_i[(i%4)*8+:8];
         end
      end
   end

   // cancel acts on the live terminal, not the latched copy
   always_comb begin
      cancel = 1'b0;
      for (int i = 0; i < 8; i++) begin
         cancel = cancel | (term_i[i] && code_ff[i*8+:8] == CODE_CANCEL);
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence rd_of(a);
      take && !we_i && adr_i == a;
   endsequence

   ack_next_a: assert property (take |=> ack_o) else $error("request not acked next cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack wider than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   mon_idle_a: assert property (take && !we_i && adr_i inside {[REG_MON_DIO:REG_MON_AO]} && sel_ff == 8'h00
      |=> dat_o == 32'h0) else $error("monitor not zero while idle");
   sel_read_a: assert property (rd_of(REG_MONSEL) |=> dat_o[7:0] == sel_ff)
      else $error("step select readback wrong");
   en_read_a: assert property (rd_of(REG_CTRL) |=> dat_o[0] == en_ff)
      else $error("enable readback wrong");
   cancel_clr_a: assert property (cancel [*3] |-> logic_out_o == 10'h000)
      else $error("outputs not cleared by cancel");
   out_hold_a: assert property ($changed(logic_out_o) && !cancel
      |=> ($stable(logic_out_o) || cancel || $past(cancel)) [*8]) else $error("outputs changed in pieces");
endmodule

bind sles_engine sles_engine_sva #(.MS_CYCLES(MS_CYCLES), .AIN_W(AIN_W)) u_sles_engine_sva (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .term_i(term_i), .ain0_i(ain0_i), .ain1_i(ain1_i),
   .logic_out_o(logic_out_o));

/* tb/sles_field_model.sv */
// field side: input terminals and analog channels
`timescale 1ns/1ps
module sles_field_model (
   // clock
   input  wire logic  clk_i,
   // field levels
   output logic [7:0]  term_o,
   output logic [15:0] ain0_o,
   output logic [15:0] ain1_o
);
   initial begin
      term_o = 8'h00;
      ain0_o = 16'h1234;
      ain1_o = 16'h5678;
   end

   // levels stand until the next call; cancel and clear stay up as long as asked
   task automatic put(input logic [7:0] t);
      @(posedge clk_i);
      term_o <= t;
   endtask

   // analog levels are taken by the engine only at the next cycle start
   task automatic put_ain(input logic [15:0] a0, input logic [15:0] a1);
      @(posedge clk_i);
      ain0_o <= a0;
      ain1_o <= a1;
   endtask
endmodule

/* tb/sles_engine_tb.sv */
// self-checking bench for the scan engine
`timescale 1ns/1ps
module sles_engine_tb;
   import sles_pkg::*;
   localparam int MS = 20;
   logic        clk_i;
   logic        rst_i;
   logic        cyc_i;
   logic        stb_i;
   logic        we_i;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [7:0]  term_i;
   logic [15:0] ain0_i;
   logic [15:0] ain1_i;
   logic [9:0]  logic_out_o;
   logic [9:0]  v;
   logic [31:0] q;
   int          fails;
   int          n_checks;
   int          n;
   logic [3:0]  be = 4'hf;
   logic [31:0] prog[5] = '{32'h000f1f01, 32'h00000034, 32'h00000014, 32'h00400f25, 32'h00000054};

   sles_engine #(.MS_CYCLES(MS)) u_sles_engine (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .term_i(term_i), .ain0_i(ain0_i), .ain1_i(ain1_i), .logic_out_o(logic_out_o));
   sles_field_model u_sles_field_model (.clk_i(clk_i), .term_o(term_i), .ain0_o(ain0_i), .ain1_o(ain1_i));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, e);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= be;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20) begin
         chk(32'h1, 32'h0);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // returns just after the oscillating step flips, i.e. right after an update
   task automatic tog(output int c);
      logic b;
      b = logic_out_o[4];
      c = 0;
      while (logic_out_o[4] === b && c < 2000) begin
         @(posedge clk_i);
         c++;
      end
   endtask

   task automatic t_reset();
      logic [7:0] r[6] = '{REG_CTRL, REG_PERIOD, REG_NSTEPS, REG_MONSEL, REG_STATUS, 8'h3c};
      wr(8'h3c, 32'hffffffff);
      // an 8-bit register ignores a write without its low byte lane
      be = 4'he;
      wr(REG_NSTEPS, 32'h000000ff);
      be = 4'hf;
      foreach (r[i]) rdc(r[i], 32'h0);
      for (int a = REG_MON_DIO; a <= REG_MON_AO; a += 4) rdc(8'(a), 32'h0);
   endtask

   task automatic t_order();
      wr(REG_PERIOD, 32'h2);
      wr(REG_NSTEPS, 32'h5);
      // upper lane only: the other lanes would turn terminals 0..2 into timer clears
      be = 4'h8;
      wr(REG_TASG_LO, 32'h50515151);
      be = 4'hf;
      rdc(REG_TASG_LO, 32'h50000000);
      wr(REG_TASG_HI, 32'h00000051);
      for (int i = 0; i < 5; i++) begin
         wr(REG_PADDR, 32'(i + 1));
         wr(REG_PDATA, prog[i]);
         wr(REG_OSEL0 + 8'(4 * i), 32'(i + 1));
      end
      wr(REG_CTRL, 32'h1);
      tog(n);
      chk(logic_out_o[3:0], 4'h6);
      tog(n);
      chk(logic_out_o[3:0], 4'h4);
      u_sles_field_model.put(8'h03);
      tog(n);
      chk(logic_out_o[3:0], 4'h1);
      tog(n);
      chk(logic_out_o[3:0], 4'h3);
      // a short dip between two latch points must go unseen
      u_sles_field_model.put(8'h01);
      repeat (10) @(posedge clk_i);
      u_sles_field_model.put(8'h03);
      tog(n);
      chk(logic_out_o[3:0], 4'h3);
   endtask

   task automatic t_period();
      int p[6] = '{2, 5, 10, 20, 0, 3};
      int e[6] = '{2, 5, 10, 20, 2, 2};
      foreach (p[i]) begin
         wr(REG_PERIOD, 32'(p[i]));
         tog(n);
         tog(n);
         tog(n);
         chk(32'(n), 32'(e[i] * MS));
      end
      wr(REG_PERIOD, 32'h2);
   endtask

   task automatic t_hold(input logic [7:0] a, input logic [31:0] d);
      tog(n);
      wr(a, d);
      repeat (10) @(posedge clk_i);
      v = logic_out_o;
      u_sles_field_model.put(8'h00);
      repeat (4 * 2 * MS) @(posedge clk_i);
      chk(logic_out_o, v);
   endtask

   task automatic t_gate();
      t_hold(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h1);
      repeat (3 * 2 * MS) @(posedge clk_i);
      chk(logic_out_o[3:0], 4'h4);
      t_hold(REG_NSTEPS, 32'd11);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[3], 1'b1);
      wr(REG_NSTEPS, 32'h5);
   endtask

   task automatic t_cancel();
      u_sles_field_model.put(8'h0b);
      repeat (2 * 2 * MS) @(posedge clk_i);
      chk(logic_out_o, 10'h000);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[1], 1'b1);
      u_sles_field_model.put(8'h03);
      repeat (3 * 2 * MS) @(posedge clk_i);
      chk(logic_out_o[3:0], 4'h3);
   endtask

   task automatic t_timer();
      wr(REG_MONSEL, 32'h4);
      u_sles_field_model.put(8'h07);
      repeat (3) tog(n);
      chk(logic_out_o[3], 1'b1);
      rdc(REG_MON_TMR, 32'h4);
      rdc(REG_MON_DIO, 32'h5);
      u_sles_field_model.put(8'h17);
      repeat (2) tog(n);
      chk(logic_out_o[3], 1'b0);
      u_sles_field_model.put(8'h07);
      tog(n);
      rdc(REG_MON_TMR, 32'h2);
      tog(n);
      chk(logic_out_o[3], 1'b1);
      // step 1 becomes an adder of both channels; monitors refresh only at its next evaluation
      wr(REG_MONSEL, 32'h1);
      u_sles_field_model.put_ain(16'h0abc, 16'h0def);
      wr(REG_PADDR, 32'h1);
      wr(REG_PDATA, 32'h00001007);
      tog(n);
      rdc(REG_MON_AI1, 32'h0abc);
      rdc(REG_MON_AI2, 32'h0def);
      rdc(REG_MON_AO, 32'h18ab);
      wr(REG_MON_AO, 32'hffffffff);
      rdc(REG_MON_AO, 32'h18ab);
      wr(REG_MONSEL, 32'h0);
      rdc(REG_MON_TMR, 32'h0);
      wr(REG_MONSEL, 32'h5);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(REG_MONSEL, 32'h0);
   endtask

   initial begin
      rst_i    = 1'b1;
      cyc_i    = 1'b0;
      stb_i    = 1'b0;
      we_i     = 1'b0;
      adr_i    = 8'h00;
      sel_i    = 4'hf;
      dat_i    = 32'h0;
      fails    = 0;
      n_checks = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_order();
      t_period();
      t_gate();
      t_cancel();
      t_timer();
      stop_test();
   end

   // the whole run needs well under 20000 clocks
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test();
   end
endmodule
